/* rtl/seq_ctrl_pkg.sv */
// package: register offsets, control and status field positions, carriers
// assumes: a simple register port at the device's register space
package seq_ctrl_pkg;
  localparam logic [11:0] sequencer_control_off = 12'h120;
  localparam logic [11:0] sequencer_status_off = 12'h124;
  localparam logic [11:0] buffer_length_off = 12'h130;
  localparam logic [11:0] conversion_count_off = 12'h134;
  localparam int ctl_status_writeback_enable = 18;
  localparam int ctl_dma_reset = 17;
  localparam int ctl_dma_controller_enable = 16;
  localparam int ctl_sample_fifo_clear = 8;
  localparam int ctl_conversion_clock_select = 5;
  localparam int ctl_normal_run_start = 3;
  localparam int ctl_acquisition_mode_select = 2;
  localparam int ctl_sampler_soft_reset = 1;
  localparam int ctl_sampler_enable = 0;
  localparam logic [31:0] ctl_rw_mask = 32'h0005_0025;
  localparam logic [31:0] ctl_reset = 32'h0000_0000;
  localparam int sts_term_lo = 20;
  localparam int sts_dma_error = 18;
  localparam int sts_dma_busy = 17;
  localparam int sts_dma_idle = 16;
  localparam int sts_frame_overrun_error = 6;
  localparam int sts_conversion_overrun_error = 5;
  localparam int sts_fifo_overflow_error = 4;
  localparam int channels = 8;
  localparam int sample_width = 16;
  localparam int fifo_depth = 32;
  localparam int buf_len_width = 16;
  localparam logic [15:0] count_reset = 16'h0001;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } dma_word_t;
endpackage

/* rtl/sample_fifo.sv */
// sample fifo: flip-flop storage, valid/ready on both sides
// assumes: one clock, synchronous flush
`timescale 1ns/1ps
module sample_fifo #(
  parameter int width = 128,
  parameter int depth = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data,
  output logic [$clog2(depth):0] level
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wptr;
  logic [aw-1:0] rptr;
  logic push;
  logic pop;

  assign in_ready = (level != depth[aw:0]);
  assign out_valid = (level != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
    end else if (flush) begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      level <= level + (aw+1)'(push) - (aw+1)'(pop);
    end
  end
endmodule

/* rtl/adc_sequencer_control.sv */
// adc sequencer control: control/status registers, input unit, dma engine control
// assumes: register port strobes are one-cycle; dma master handshakes via dma_* ports
`timescale 1ns/1ps
module adc_sequencer_control
  import seq_ctrl_pkg::*;
#(
  parameter int depth = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input seq_ctrl_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic conv_clk_one,
  input wire logic conv_clk_two,
  input wire logic frame_trigger,
  input wire logic converter_busy,
  input wire logic converter_operating_mode,
  output logic conversion_start,
  input wire logic sample_valid,
  input wire logic [channels*sample_width-1:0] sample_data,
  output logic [channels*sample_width-1:0] dma_data,
  output logic dma_data_valid,
  input wire logic dma_data_ready,
  input wire logic dma_buffer_full,
  input wire logic dma_bus_error,
  output logic dma_active,
  output logic status_write_req,
  input wire logic status_write_done,
  output logic [31:0] status_write_data
);
  import seq_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // types and signals
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    dma_idle = 3'b000,
    dma_busy = 3'b001,
    dma_status = 3'b010,
    dma_halted = 3'b011
  } dma_state_t;

  logic [31:0] ctrl;
  logic [15:0] count_cfg;
  logic [15:0] conv_left;
  logic running;
  logic halted;
  logic frame_err;
  logic conversion_overrun_error;
  logic ovf_err;
  logic [2:0] term;
  logic dma_err;
  dma_state_t dma_state;
  logic wr_ctl;
  logic wr_len;
  logic sampler_rst;
  logic dma_rst;
  logic fifo_clear;
  logic pace;
  logic pace_d;
  logic tick;
  logic start_pending;
  logic start_req;
  logic fifo_in_ready;
  logic fifo_push;
  logic [$clog2(depth):0] fifo_level;
  logic [31:0] status_word;

  function automatic logic wr_at(input reg_req_t r, input logic [11:0] off);
    return r.wr && (r.addr == off);
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_ctl = wr_at(reg_req, sequencer_control_off);
  assign wr_len = wr_at(reg_req, buffer_length_off);
  assign sampler_rst = !ctrl[ctl_sampler_enable] ||
    (wr_ctl && reg_req.wdata[ctl_sampler_soft_reset]);
  assign dma_rst = (wr_ctl && reg_req.wdata[ctl_dma_reset]);
  assign fifo_clear = wr_ctl && reg_req.wdata[ctl_sample_fifo_clear];

  // normal start, also honoured in the very write that enables the sampler
  assign start_req = wr_ctl && reg_req.wdata[ctl_normal_run_start] && reg_req.wdata[ctl_sampler_enable] &&
    !reg_req.wdata[ctl_acquisition_mode_select] && !reg_req.wdata[ctl_sampler_soft_reset];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= ctl_reset;
    end else if (wr_ctl) begin
      ctrl <= reg_req.wdata & ctl_rw_mask;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_cfg <= count_reset;
    end else if (wr_at(reg_req, conversion_count_off)) begin
      count_cfg <= reg_req.wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // conversion pacing and input unit
  // ----------------------------------------------------------------
  assign pace = ctrl[ctl_conversion_clock_select] ? conv_clk_two : conv_clk_one;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pace_d <= 1'b0;
    end else begin
      pace_d <= pace;
    end
  end

  assign tick = pace && !pace_d;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_pending <= 1'b0;
      running <= 1'b0;
      conv_left <= '0;
      conversion_start <= 1'b0;
    end else if (sampler_rst || halted) begin
      // a start written together with the enable survives the reset cycle
      start_pending <= sampler_rst && start_req;
      running <= 1'b0;
      conv_left <= '0;
      conversion_start <= 1'b0;
    end else begin
      conversion_start <= 1'b0;
      if (start_req) begin
        start_pending <= 1'b1;
      end else if (ctrl[ctl_acquisition_mode_select] && frame_trigger && !running) begin
        start_pending <= 1'b1;
      end
      if (tick && (running || start_pending) && !converter_busy) begin
        conversion_start <= converter_operating_mode;
        start_pending <= 1'b0;
        running <= (running ? conv_left : count_cfg) > 16'h0001;
        conv_left <= (running ? conv_left : count_cfg) - 16'h0001;
      end
    end
  end

  // input unit error flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_err <= 1'b0;
      conversion_overrun_error <= 1'b0;
      ovf_err <= 1'b0;
    end else if (sampler_rst) begin
      frame_err <= 1'b0;
      conversion_overrun_error <= 1'b0;
      ovf_err <= 1'b0;
    end else if (!halted) begin
      if (ctrl[ctl_acquisition_mode_select] && frame_trigger && running) begin
        frame_err <= 1'b1;
      end
      if (tick && (running || start_pending) && converter_busy) begin
        conversion_overrun_error <= 1'b1;
      end
      if (sample_valid && !fifo_in_ready) begin
        ovf_err <= 1'b1;
      end
    end
  end

  assign halted = frame_err || conversion_overrun_error || ovf_err;
  assign fifo_push = sample_valid && ctrl[ctl_sampler_enable] && !halted;

  // ----------------------------------------------------------------
  // sample fifo
  // ----------------------------------------------------------------
  sample_fifo #(
    .width(channels*sample_width),
    .depth(depth)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(fifo_clear),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(sample_data),
    .out_valid(dma_data_valid),
    .out_ready(dma_data_ready && dma_state == dma_busy),
    .out_data(dma_data),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------
  // dma controller
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_state <= dma_idle;
      dma_err <= 1'b0;
    end else if (dma_rst || (!ctrl[ctl_dma_controller_enable] && dma_state != dma_busy)) begin
      dma_state <= dma_idle;
      dma_err <= 1'b0;
    end else begin
      case (dma_state)
        dma_idle: begin
          if (wr_len && ctrl[ctl_dma_controller_enable]) begin
            dma_state <= dma_busy;
          end
        end
        dma_busy: begin
          if (dma_bus_error) begin
            dma_err <= 1'b1;
            dma_state <= dma_halted;
          end else if (dma_buffer_full || (halted && !dma_data_valid)) begin
            dma_state <= ctrl[ctl_status_writeback_enable] ? dma_status : dma_idle;
          end
        end
        dma_status: begin
          if (status_write_done) begin
            dma_state <= dma_idle;
          end
        end
        dma_halted: begin
          dma_state <= dma_halted;
        end
        default: begin
          dma_state <= dma_idle;
        end
      endcase
    end
  end

  // termination causes: error, buffer end; the middle bit (block end) is always 0
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      term <= 3'b000;
    end else if (dma_state == dma_busy && (dma_buffer_full || (halted && !dma_data_valid))) begin
      term <= {halted, 1'b0, dma_buffer_full};
    end else if (wr_len) begin
      term <= 3'b000;
    end
  end

  assign dma_active = (dma_state == dma_busy);
  assign status_write_req = (dma_state == dma_status);

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[sts_term_lo +: 3] = term;
    status_word[sts_dma_error] = dma_err;
    status_word[sts_dma_busy] = (dma_state == dma_busy);
    status_word[sts_dma_idle] = (dma_state == dma_idle);
    status_word[sts_frame_overrun_error] = frame_err;
    status_word[sts_conversion_overrun_error] = conversion_overrun_error;
    status_word[sts_fifo_overflow_error] = ovf_err;
  end

  assign status_write_data = status_word;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        sequencer_control_off: reg_rdata <= ctrl;
        sequencer_status_off: reg_rdata <= status_word;
        conversion_count_off: reg_rdata <= {16'h0000, count_cfg};
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule

/* tb/seq_ctrl_checker.sv */
// checker: assertions on the sequencer control ports
// assumes: bound into adc_sequencer_control, one clock
`timescale 1ns/1ps
module seq_ctrl_checker
  import seq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input seq_ctrl_pkg::reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic converter_busy,
  input wire logic conversion_start,
  input wire logic dma_active,
  input wire logic dma_buffer_full,
  input wire logic dma_bus_error,
  input wire logic status_write_req,
  input wire logic status_write_done
);
  // ----
  // shadow of the control register
  // ----
  logic [31:0] ctl;
  logic wr_ctl, wr_len;
  assign wr_ctl = reg_req.wr && reg_req.addr == sequencer_control_off;
  assign wr_len = reg_req.wr && reg_req.addr == buffer_length_off;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ctl <= ctl_reset;
    else if (wr_ctl) ctl <= reg_req.wdata & ctl_rw_mask;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ctl_readback: assert property (
    reg_req.rd && reg_req.addr == sequencer_control_off |=> reg_rdata == $past(ctl)) else $error("bad readback");
  chk_len_refused: assert property (wr_len && !ctl[16] && !dma_active |=> !dma_active)
    else $error("length taken while off");
  chk_finish_on_off: assert property (
    $fell(ctl[16]) && $past(dma_active) && !$past(dma_buffer_full || dma_bus_error) |-> dma_active)
    else $error("transfer cut short");
  chk_err_halts: assert property (dma_bus_error && dma_active |=> !dma_active)
    else $error("dma ran on after error");
  chk_dma_reset: assert property (wr_ctl && reg_req.wdata[17] |-> ##[1:2] !dma_active)
    else $error("dma reset ignored");
  chk_wb_enable: assert property ($rose(status_write_req) |-> $past(ctl[18]))
    else $error("status write while off");
  chk_wb_holds: assert property (status_write_req && !status_write_done |=> status_write_req)
    else $error("status write dropped");
  chk_start_enabled: assert property (conversion_start |-> $past(ctl[0]))
    else $error("conversion while sampler off");
  chk_busy_blocks: assert property (conversion_start |-> !$past(converter_busy))
    else $error("conversion while busy");
  cover property (conversion_start);
  cover property (status_write_req && status_write_done);
  cover property (dma_bus_error && dma_active);
endmodule
bind adc_sequencer_control seq_ctrl_checker i_chk (.clk(clk), .nrst(nrst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .converter_busy(converter_busy), .conversion_start(conversion_start),
  .dma_active(dma_active), .dma_buffer_full(dma_buffer_full), .dma_bus_error(dma_bus_error),
  .status_write_req(status_write_req), .status_write_done(status_write_done));

/* tb/host_ram_model.sv */
// host ram model: drains dma words with stalls, acks status writes
// assumes: shares the design clock
`timescale 1ns/1ps
module host_ram_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dma_active,
  input wire logic dma_data_valid,
  output logic dma_data_ready,
  output logic dma_buffer_full,
  output logic dma_bus_error,
  input wire logic status_write_req,
  output logic status_write_done,
  input wire logic fail_now
);
  // ----
  // eight-word buffers, ready every other cycle
  // ----
  logic [3:0] got;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {dma_data_ready, dma_buffer_full, dma_bus_error, status_write_done, got} <= '0;
    end else begin
      dma_data_ready <= ~dma_data_ready;
      dma_buffer_full <= dma_active && dma_data_valid && dma_data_ready && got == 4'h7;
      got <= !dma_active ? 4'h0 : got + 4'(dma_data_valid && dma_data_ready);
      dma_bus_error <= fail_now && dma_active && !dma_bus_error;
      status_write_done <= status_write_req && !status_write_done;
    end
  end
endmodule

/* tb/testbench.sv */
// testbench: register rows, pacing runs, input unit errors, dma transfers
// assumes: host_ram_model on the dma side, checker bound to the design
`timescale 1ns/1ps
module testbench;
  import seq_ctrl_pkg::*;
  logic clk, nrst, c1, c2, trig, sv, stuck, fail_now, rdy, full, berr, swr, swd, act, dv, cs, busy;
  logic [1:0] run;
  logic [7:0] bc;
  logic [15:0] sid, rx, r0;
  logic [127:0] sd, dd;
  logic [31:0] rdat;
  reg_req_t req;
  int error_cnt = 0, n_compared = 0, nst = 0, n0 = 0, pc = 0;
  logic [31:0] rows [4][3] = '{'{32'h120, 32'hffff_ffff, 32'h0005_0025},
    '{32'h120, 32'h0002_010a, 32'h0}, '{32'h134, 32'h3, 32'h3}, '{32'h1fc, 32'hffff_ffff, 32'h0}};
  assign busy = stuck || bc != 8'h0;
  assign sd = {8{sid}};
  adc_sequencer_control i_dut (.clk(clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdat), .conv_clk_one(c1),
    .conv_clk_two(c2), .frame_trigger(trig), .converter_busy(busy), .converter_operating_mode(1'b1),
    .conversion_start(cs), .sample_valid(sv), .sample_data(sd), .dma_data(dd), .dma_data_valid(dv),
    .dma_data_ready(rdy), .dma_buffer_full(full), .dma_bus_error(berr), .dma_active(act),
    .status_write_req(swr), .status_write_done(swd), .status_write_data());
  host_ram_model i_host (.clk(clk), .nrst(nrst), .dma_active(act), .dma_data_valid(dv),
    .dma_data_ready(rdy), .dma_buffer_full(full), .dma_bus_error(berr),
    .status_write_req(swr), .status_write_done(swd), .fail_now(fail_now));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----
  // pacing clocks and converter model
  // ----
  always @(posedge clk) begin
    pc <= (pc == 129) ? 0 : pc + 1; // 260-cycle period, above conversion time
    if (pc == 129) begin
      c1 <= run[0] & ~c1;
      c2 <= run[1] & ~c2;
    end
    sv <= bc == 8'h1;
    if (sv) sid <= sid + 16'h1;
    if (cs) bc <= 8'h64;
    else if (bc != 8'h0) bc <= bc - 8'h1;
    if (cs) nst <= nst + 1;
    if (act && dv && rdy) begin
      chk(dd[31:0], {2{rx}});
      rx = rx + 16'h1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req <= '0;
    #1 chk(rdat & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse_trig; // pacing derives from clk, so it stays locked
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
  // ----
  // main sequence
  // ----
  initial begin
    nrst = 1'b0;
    req = '0;
    {c1, c2, trig, sv, stuck, fail_now, run, bc, sid, rx} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(sequencer_control_off, 32'hffff_ffff, 32'h0);
    rd_chk(conversion_count_off, 32'hffff_ffff, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(rows[i][0][11:0], rows[i][1]);
      rd_chk(rows[i][0][11:0], 32'hffff_ffff, rows[i][2]);
    end
    for (int s = 0; s < 2; s++) begin
      wr(sequencer_control_off, 32'h0);
      wr(sequencer_control_off, 32'h9 | 32'(s << 5));
      n0 = nst;
      run <= (s == 1) ? 2'b01 : 2'b10;
      cyc(1400);
      chk(32'(nst - n0), 32'h0);
      run <= (s == 1) ? 2'b10 : 2'b01;
      cyc(1400);
      chk(32'(nst - n0), 32'h3);
      run <= 2'b00;
    end
    wr(sequencer_control_off, 32'h0);
    stuck <= 1'b1;
    n0 = nst;
    wr(sequencer_control_off, 32'h9);
    run <= 2'b01;
    cyc(600);
    rd_chk(sequencer_status_off, 32'h70, 32'h20);
    stuck <= 1'b0;
    cyc(600);
    chk(32'(nst - n0), 32'h0);
    wr(sequencer_control_off, 32'h0);
    rd_chk(sequencer_status_off, 32'h70, 32'h0);
    wr(conversion_count_off, 32'h4);
    wr(sequencer_control_off, 32'h5);
    n0 = nst;
    cyc(300);
    chk(32'(nst - n0), 32'h0);
    pulse_trig;
    cyc(600);
    chk(32'(nst - n0 >= 2), 32'h1);
    pulse_trig;
    cyc(10);
    rd_chk(sequencer_status_off, 32'h70, 32'h40);
    n0 = nst;
    cyc(600);
    chk(32'(nst - n0), 32'h0);
    wr(sequencer_control_off, 32'h100); // fifo known empty before the normal start
    rx = sid;
    wr(conversion_count_off, 32'h28);
    wr(sequencer_control_off, 32'h9);
    cyc(9200);
    run <= 2'b00;
    rd_chk(sequencer_status_off, 32'h70, 32'h10);
    wr(sequencer_control_off, 32'h0005_0001);
    wr(buffer_length_off, 32'h0);
    cyc(100);
    // buffer end plus error cause, since the overflow stopped the input unit
    rd_chk(sequencer_status_off, 32'h0077_0000, 32'h0051_0000);
    wr(buffer_length_off, 32'h0);
    rd_chk(sequencer_status_off, 32'h0070_0000, 32'h0);
    fail_now <= 1'b1;
    cyc(20);
    fail_now <= 1'b0;
    rd_chk(sequencer_status_off, 32'h0007_0000, 32'h0004_0000);
    wr(sequencer_control_off, 32'h0003_0001);
    rd_chk(sequencer_status_off, 32'h0007_0000, 32'h0001_0000);
    r0 = rx;
    wr(buffer_length_off, 32'h0);
    wr(sequencer_control_off, 32'h1);
    cyc(100);
    chk(32'(rx - r0), 32'h8);
    wr(buffer_length_off, 32'h0);
    cyc(3);
    chk({31'h0, act}, 32'h0);
    give_verdict;
  end
endmodule
